// File: verilog/isx_exec.sv
module isx_exec (
  input wire logic CLK,
  input wire logic RST,
  input wire logic INSTR_VALID,
  input wire isx_pkg::isx_instr_t INSTR,
  input wire isx_pkg::isx_byte_t FILE_RDATA,
  output logic QUARTER_ONE,
  output logic NOP_CYCLE,
  output isx_pkg::isx_addr_t FILE_ADDR,
  output logic FILE_RD,
  output logic FILE_WE,
  output isx_pkg::isx_byte_t FILE_WDATA,
  output isx_pkg::isx_byte_t W,
  output logic ZERO
);
  import isx_pkg::*;

  isx_q_e q_r;
  isx_q_e q_nxt;
  isx_dec_s ir_r;
  isx_dec_s dec_w;
  isx_byte_t opnd_r;
  isx_byte_t res_r;
  logic res_zero_r;
  isx_byte_t alu_res;
  logic alu_zero;
  logic take_w;
  logic uses_file_w;
  logic w_dest_w;
  logic f_dest_w;
  logic z_upd_w;

  // Decode and destination selection
  assign dec_w = isx_decode(INSTR);
  // Word offered during the no-op cycle is the discarded one
  assign take_w = (q_r == ISX_Q1) && INSTR_VALID && !NOP_CYCLE;
  assign uses_file_w = (dec_w.op == ISX_OP_INC_SKIP) ||
                       (dec_w.op == ISX_OP_OR_FILE);
  assign w_dest_w = (ir_r.op == ISX_OP_OR_LIT) ||
                    ((ir_r.op != ISX_OP_NONE) && !ir_r.dest);
  assign f_dest_w = ((ir_r.op == ISX_OP_INC_SKIP) ||
                     (ir_r.op == ISX_OP_OR_FILE)) && ir_r.dest;
  // Increment-skip leaves the zero flag alone
  assign z_upd_w = (ir_r.op == ISX_OP_OR_LIT) ||
                   (ir_r.op == ISX_OP_OR_FILE);

  isx_alu u_alu (
    .op(ir_r.op),
    .w_val(W),
    .opnd(opnd_r),
    .result(alu_res),
    .zero(alu_zero)
  );

  // Free-running quarter sequence, one clock per quarter
  always_comb
  begin
    unique case (q_r)
      ISX_Q1: q_nxt = ISX_Q2;
      ISX_Q2: q_nxt = ISX_Q3;
      ISX_Q3: q_nxt = ISX_Q4;
      ISX_Q4: q_nxt = ISX_Q1;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      q_r <= ISX_Q1;
      QUARTER_ONE <= 1'b1;
    end
    else
    begin
      q_r <= q_nxt;
      QUARTER_ONE <= (q_nxt == ISX_Q1);
    end
  end

  // Q1: decode; an idle or skipped slot holds no operation
  always_ff @(posedge CLK)
  begin
    if (RST)
      ir_r <= '0;
    else if (q_r == ISX_Q1)
      ir_r <= take_w ? dec_w : '0;
  end

  // Q2: file read strobe; register data or literal latched at its end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      FILE_RD <= 1'b0;
      FILE_ADDR <= '0;
      opnd_r <= ISX_ZERO_BYTE;
    end
    else
    begin
      FILE_RD <= take_w && uses_file_w;
      if (take_w)
        FILE_ADDR <= dec_w.addr;
      if (q_r == ISX_Q2)
        opnd_r <= (ir_r.op == ISX_OP_OR_LIT) ? ir_r.lit : FILE_RDATA;
    end
  end

  // Q3: process data, stage the file write for Q4
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      res_r <= ISX_ZERO_BYTE;
      res_zero_r <= 1'b0;
      FILE_WE <= 1'b0;
      FILE_WDATA <= ISX_ZERO_BYTE;
    end
    else
    begin
      FILE_WE <= (q_r == ISX_Q3) && f_dest_w;
      if (q_r == ISX_Q3)
      begin
        res_r <= alu_res;
        res_zero_r <= alu_zero;
        FILE_WDATA <= alu_res;
      end
    end
  end

  // Q4: write W unless the file is the destination, zero for the ORs only; arm the no-op cycle when the count hits zero
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      W <= ISX_W_RST;
      ZERO <= ISX_Z_RST;
      NOP_CYCLE <= 1'b0;
    end
    else if (q_r == ISX_Q4)
    begin
      if (w_dest_w)
        W <= res_r;
      if (z_upd_w)
        ZERO <= res_zero_r;
      NOP_CYCLE <= (ir_r.op == ISX_OP_INC_SKIP) && res_zero_r;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  inc_status_keep_a: assert property (
    (q_r == ISX_Q4 && ir_r.op == ISX_OP_INC_SKIP) |=> $stable(ZERO))
    else $error("Increment-skip changed the zero flag");
  inc_file_write_a: assert property (
    (q_r == ISX_Q3 && ir_r.op == ISX_OP_INC_SKIP && ir_r.dest) |=>
    (FILE_WE && FILE_WDATA == isx_byte_t'($past(opnd_r) + ISX_ONE)))
    else $error("Increment result not written to file");
  inc_w_write_a: assert property (
    (q_r == ISX_Q4 && ir_r.op == ISX_OP_INC_SKIP && !ir_r.dest) |=>
    (W == $past(res_r) && !FILE_WE))
    else $error("Increment result not written to W");
  skip_nop_a: assert property (
    (q_r == ISX_Q4 && ir_r.op == ISX_OP_INC_SKIP && res_zero_r) |=>
    NOP_CYCLE [*4] ##1 !NOP_CYCLE)
    else $error("Skip did not give exactly one no-op cycle");
  no_skip_a: assert property (
    (q_r == ISX_Q4 && ir_r.op == ISX_OP_INC_SKIP && !res_zero_r) |=>
    !NOP_CYCLE)
    else $error("No-op cycle inserted without a zero result");
  nop_idle_a: assert property (
    (NOP_CYCLE && q_r != ISX_Q1) |->
    (ir_r.op == ISX_OP_NONE && !FILE_RD && !FILE_WE))
    else $error("Activity during the skip no-op cycle");
  rd_quarter_a: assert property (
    take_w && uses_file_w |=> (FILE_RD && q_r == ISX_Q2) ##1 !FILE_RD)
    else $error("File read not confined to quarter two");
  we_quarter_a: assert property (
    FILE_WE |-> q_r == ISX_Q4)
    else $error("File write outside quarter four");
  orlit_result_a: assert property (
    (q_r == ISX_Q3 && ir_r.op == ISX_OP_OR_LIT) |=>
    (!FILE_WE ##1 W == ($past(W, 2) | $past(opnd_r, 2))))
    else $error("OR-literal result wrong or written to file");
  orlit_operand_a: assert property (
    (q_r == ISX_Q2 && ir_r.op == ISX_OP_OR_LIT) |=> opnd_r == $past(ir_r.lit))
    else $error("Literal not read in quarter two");
  orfile_calc_a: assert property (
    (q_r == ISX_Q3 && ir_r.op == ISX_OP_OR_FILE) |-> alu_res == (W | opnd_r))
    else $error("OR-with-file result wrong");
  orfile_dest_a: assert property (
    (q_r == ISX_Q3 && ir_r.op == ISX_OP_OR_FILE && ir_r.dest) |=>
    (FILE_WE && FILE_WDATA == $past(alu_res)) ##1 $stable(W))
    else $error("OR-with-file file destination wrong");
  zero_flag_a: assert property (
    (q_r == ISX_Q4 && z_upd_w) |=> ZERO == ($past(res_r) == ISX_ZERO_BYTE))
    else $error("Zero flag does not match result");
  quarter_flag_a: assert property (
    QUARTER_ONE == (q_r == ISX_Q1))
    else $error("Quarter-one flag out of step with the quarter");
  orlit_no_file_a: assert property (
    (take_w && dec_w.op == ISX_OP_OR_LIT) |=> (!FILE_RD && !FILE_WE) [*4])
    else $error("OR-literal touched the file port");
  nop_hold_a: assert property (
    (NOP_CYCLE && q_r == ISX_Q4) |=> ($stable(W) && $stable(ZERO)))
    else $error("Skip no-op cycle changed W or the zero flag");
  discard_word_a: assert property (
    (NOP_CYCLE && q_r == ISX_Q1) |=> (ir_r.op == ISX_OP_NONE && !FILE_RD))
    else $error("Word offered in the no-op cycle was taken");
endmodule : isx_exec

// File: verilog/isx_alu.sv
package isx_pkg;
  localparam int ISX_INSTR_W = 14;
  localparam int ISX_DATA_W = 8;
  localparam int ISX_ADDR_W = 7;
  // Field positions inside the 14-bit instruction word
  localparam int ISX_OPC_MSB = 13;
  localparam int ISX_OPC_LSB = 8;
  localparam int ISX_DEST_BIT = 7;
  localparam int ISX_ADDR_MSB = 6;
  localparam int ISX_LIT_MSB = 7;
  // Six-bit opcode patterns
  localparam logic [5:0] ISX_OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] ISX_OPC_OR_LIT = 6'h38;
  localparam logic [5:0] ISX_OPC_OR_FILE = 6'h04;
  // Values after reset, plus the increment step and the zero byte
  localparam logic [7:0] ISX_W_RST = 8'h00;
  localparam logic ISX_Z_RST = 1'b0;
  localparam logic [7:0] ISX_ONE = 8'h01;
  localparam logic [7:0] ISX_ZERO_BYTE = 8'h00;

  typedef logic [ISX_INSTR_W-1:0] isx_instr_t;
  typedef logic [ISX_DATA_W-1:0] isx_byte_t;
  typedef logic [ISX_ADDR_W-1:0] isx_addr_t;

  typedef enum logic [1:0] {
    ISX_OP_NONE,
    ISX_OP_INC_SKIP,
    ISX_OP_OR_LIT,
    ISX_OP_OR_FILE
  } isx_op_e;

  typedef enum logic [1:0] {ISX_Q1, ISX_Q2, ISX_Q3, ISX_Q4} isx_q_e;

  typedef struct packed {
    isx_op_e op;
    logic dest;
    isx_addr_t addr;
    isx_byte_t lit;
  } isx_dec_s;

  // Opcodes outside this block decode to no operation here
  function automatic isx_dec_s isx_decode(input isx_instr_t ins);
    isx_dec_s d;
    d.dest = ins[ISX_DEST_BIT];
    d.addr = ins[ISX_ADDR_MSB:0];
    d.lit = ins[ISX_LIT_MSB:0];
    unique case (ins[ISX_OPC_MSB:ISX_OPC_LSB])
      ISX_OPC_INC_SKIP: d.op = ISX_OP_INC_SKIP;
      ISX_OPC_OR_LIT: d.op = ISX_OP_OR_LIT;
      ISX_OPC_OR_FILE: d.op = ISX_OP_OR_FILE;
      default: d.op = ISX_OP_NONE;
    endcase
    return d;
  endfunction : isx_decode

  function automatic logic isx_is_zero(input isx_byte_t v);
    return v == ISX_ZERO_BYTE;
  endfunction : isx_is_zero
endpackage : isx_pkg

module isx_alu (
  input wire isx_pkg::isx_op_e op,
  input wire isx_pkg::isx_byte_t w_val,
  input wire isx_pkg::isx_byte_t opnd,
  output isx_pkg::isx_byte_t result,
  output logic zero
);
  import isx_pkg::*;
  // Process-data quarter: increment wraps at 8 bits, ORs are bitwise
  assign result = (op == ISX_OP_INC_SKIP) ? isx_byte_t'(opnd + ISX_ONE) :
                  (op == ISX_OP_NONE) ? ISX_ZERO_BYTE : (w_val | opnd);
  assign zero = isx_is_zero(result);
endmodule : isx_alu

// File: sim/isx_exec_bench.sv
// Compare one value, count it, report a mismatch at once
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) \
    begin \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); \
      num_errors++; \
    end \
  end

module isx_exec_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import isx_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic INSTR_VALID = 1'b0;
  isx_instr_t INSTR = 14'h0000;
  isx_byte_t FILE_RDATA = 8'h00;
  logic QUARTER_ONE, NOP_CYCLE, FILE_RD, FILE_WE, ZERO;
  isx_addr_t FILE_ADDR;
  isx_byte_t FILE_WDATA, W, w_exp;
  logic z_exp;
  int num_errors = 0;
  int num_checks = 0;
  // Corner words: skip on wrap, W destination, zero result, top address
  isx_instr_t cw[9] = '{14'h0f85, 14'h0f05, 14'h3800, 14'h0f05, 14'h3835,
    14'h0485, 14'h0405, 14'h0000, 14'h0fff};
  isx_byte_t cd[9] = '{8'hff, 8'hff, 8'h5a, 8'h10, 8'h00, 8'h0f, 8'hc0,
    8'h33, 8'hfe};
  logic [5:0] opcs[3] = '{ISX_OPC_INC_SKIP, ISX_OPC_OR_LIT, ISX_OPC_OR_FILE};

  // Half period of 2.5 ns gives 200 MHz
  always #2.5 CLK = ~CLK;

  isx_exec DUT (.CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .FILE_RDATA(FILE_RDATA), .QUARTER_ONE(QUARTER_ONE),
    .NOP_CYCLE(NOP_CYCLE), .FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD),
    .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA), .W(W), .ZERO(ZERO));

  // Inputs move 1 ns after the edge so sampling never races
  task step;
    @(posedge CLK);
    #1;
  endtask : step

  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // Result of one instruction, worked out from the word, W and the file byte
  function automatic isx_byte_t exp_res(isx_instr_t i, isx_byte_t w,
    isx_byte_t f);
    if (i[13:8] === ISX_OPC_INC_SKIP)
      return f + ISX_ONE;
    return w | ((i[13:8] === ISX_OPC_OR_LIT) ? i[7:0] : f);
  endfunction : exp_res

  task run(input isx_instr_t ins, input isx_byte_t fd);
    isx_byte_t res;
    logic inc, lit, rd, we, skip;
    int n;
    inc = ins[13:8] === ISX_OPC_INC_SKIP;
    lit = ins[13:8] === ISX_OPC_OR_LIT;
    rd = inc || ins[13:8] === ISX_OPC_OR_FILE;
    we = rd && ins[7];
    res = exp_res(ins, w_exp, fd);
    skip = inc && res === 8'h00;
    n = 0;
    while ((QUARTER_ONE !== 1'b1 || NOP_CYCLE !== 1'b0) && n < 20)
    begin
      step();
      n++;
    end
    if (n >= 20)
    begin
      num_errors++;
      end_sim();
    end
    INSTR_VALID = 1'b1;
    INSTR = ins;
    FILE_RDATA = fd;
    step();
    INSTR_VALID = 1'b0;
    INSTR = ~ins;
    `CHK(QUARTER_ONE, 1'b0)
    `CHK(FILE_RD, rd)
    if (rd) `CHK(FILE_ADDR, ins[6:0])
    step();
    FILE_RDATA = ~fd;
    step();
    `CHK(FILE_WE, we)
    if (we) `CHK(FILE_WDATA, res)
    if ((rd || lit) && !we)
      w_exp = res;
    if (rd && !inc || lit)
      z_exp = res === 8'h00;
    step();
    `CHK(W, w_exp)
    `CHK(ZERO, z_exp)
    `CHK(NOP_CYCLE, skip)
    `CHK(QUARTER_ONE, 1'b1)
    if (skip)
    begin
      // Word offered in the no-op cycle must leave no trace
      INSTR_VALID = 1'b1;
      INSTR = {ISX_OPC_OR_LIT, 8'hff};
      step();
      INSTR_VALID = 1'b0;
      step();
      step();
      `CHK(NOP_CYCLE, 1'b1)
      step();
      `CHK(NOP_CYCLE, 1'b0)
      `CHK(W, w_exp)
    end
  endtask : run

  initial
  begin
    void'($urandom(15));
    w_exp = ISX_W_RST;
    z_exp = ISX_Z_RST;
    repeat (10) @(posedge CLK);
    #1;
    RST = 1'b0;
    `CHK(W, ISX_W_RST)
    `CHK(QUARTER_ONE, 1'b1)
    foreach (cw[k]) run(cw[k], cd[k]);
    $display("test corner done");
    // Reset in the middle of an OR-literal must abort it with no trace
    INSTR_VALID = 1'b1;
    INSTR = {ISX_OPC_OR_LIT, 8'hff};
    step();
    INSTR_VALID = 1'b0;
    step();
    RST = 1'b1;
    step();
    RST = 1'b0;
    w_exp = ISX_W_RST;
    z_exp = ISX_Z_RST;
    `CHK(W, ISX_W_RST)
    `CHK(ZERO, ISX_Z_RST)
    `CHK(QUARTER_ONE, 1'b1)
    `CHK(FILE_RD, 1'b0)
    `CHK(NOP_CYCLE, 1'b0)
    $display("test reset done");
    repeat (60)
      run({opcs[$urandom % 3], 8'($urandom)},
        ($urandom % 4 == 0) ? 8'hff : 8'($urandom));
    $display("test random done");
    end_sim();
  end
endmodule : isx_exec_bench
